// file: shared/iwtc_pkg.sv
package iwtc_pkg;
  // data-memory addresses of the block's registers
  localparam logic [6:0] ADR_TMR = 7'h01;
  localparam logic [6:0] ADR_STAT = 7'h03;
  localparam logic [6:0] ADR_PORTA = 7'h05;
  localparam logic [6:0] ADR_WAKE = 7'h20;
  localparam logic [6:0] ADR_IRQ_EN = 7'h21;
  localparam logic [6:0] ADR_IRQ_PD = 7'h22;
  // field positions
  localparam int B_GIE = 7;
  localparam int B_EXT = 2;
  localparam int B_TMR = 0;
  localparam int B_TO = 4;
  localparam int B_PD = 3;
  // values after reset
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [5:0] SEL_RST = 6'h3f;
  localparam logic [7:0] IO_DIRECTION_RST = 8'hff;
  localparam logic [10:0] PC_RST = 11'h7ff;
  localparam logic [10:0] IRQ_VEC = 11'h7fe;
  localparam logic [7:0] SYNC_RST = 8'h7f;
  // cold-reset setup time, in ms and in cycles of the 25 MHz clock
  localparam int CLK_HZ = 25_000_000;
  localparam int SETUP_MS = 20;
  localparam int SETUP_CYC = SETUP_MS * (CLK_HZ / 1000);
  // select register, loaded by the select instruction
  typedef struct packed {
    logic src_ext;   // 1: count the timer clock pin
    logic edge_fall; // 1: count falling edges
    logic prescaler_assign;       // 1: prescaler serves the watchdog
    logic [2:0] ps;  // prescale ratio
  } iwtc_sel_t;
  // wake control register layout
  typedef struct packed {
    logic soft_en;   // watchdog software enable
    logic wake_en;   // external wake-up enable
    logic irq_sel;   // port a bit 0 is an interrupt pin
    logic rsvd;      // unimplemented, reads zero
    logic [3:0] pa_bits;
  } iwtc_wake_t;
endpackage

// file: core/iwtc_ctrl.sv
`timescale 1ns/1ps
module iwtc_ctrl #(
  parameter int SETUP_CYC_P = iwtc_pkg::SETUP_CYC
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // configuration word
  input wire logic adv_mode_i,
  input wire logic cfg_wdt_fuse_i,
  input wire logic [1:0] cfg_lvr_sel_i,
  // core data access
  input wire logic [6:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  // special instructions
  input wire logic [7:0] acc_i,
  input wire logic op_select_i,
  input wire logic op_io_direction_i,
  input wire logic op_clrwdt_i,
  input wire logic op_sleep_i,
  input wire logic op_reti_i,
  // pins and analog sources
  input wire logic [3:0] pa_pin_i,
  input wire logic tclk_pin_i,
  input wire logic reset_pin_n_i,
  input wire logic wdt_rc_i,
  input wire logic [3:0] lvd_trip_i,
  // to the core
  output logic sys_rst_o,
  output logic [10:0] reset_vec_o,
  output logic irq_take_o,
  output logic [10:0] irq_vec_o,
  output logic sleep_o,
  output logic [7:0] io_direction_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o
);
  import iwtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // index of an extra general byte: bank minus one, low three bits
  function automatic logic [4:0] gpr_idx(input logic [6:0] a);
    gpr_idx = {2'(a[6:5] - 2'd1), a[2:0]};
  endfunction
  // prescaler mask: timer divides by 2^(ps+1), watchdog by 2^ps
  function automatic logic [7:0] ps_mask(input logic [2:0] ps,
                                         input logic wdt);
    ps_mask = wdt ? 8'((9'h001 << ps) - 9'h001)
                  : 8'((9'h002 << ps) - 9'h001);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] pin_w;  // raw asynchronous inputs
  logic [7:0] s1_q;   // first stage, read by s2 only
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] f_q;    // filtered level
  logic [7:0] f_d;
  logic [7:0] fall_w;
  logic [7:0] rise_w;
  assign pin_w = {lvd_trip_i[cfg_lvr_sel_i], reset_pin_n_i, wdt_rc_i,
                  tclk_pin_i, pa_pin_i};
  // a change counts only once stages two and three agree
  assign f_d = (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
  assign fall_w = f_q & ~f_d;
  assign rise_w = ~f_q & f_d;

  // four flops per pin; pulses under two cycles may vanish
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      f_q <= SYNC_RST;
    end else begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state declarations
  iwtc_wake_t wake_q;      // wake control
  iwtc_sel_t sel_q;        // select register
  logic [7:0] io_direction_q;     // io direction
  logic [7:0] tmr_q;       // timer count
  logic [7:0] pre_q;       // shared prescaler
  logic [7:0] wdt_q;       // watchdog count
  logic gie_q;             // global enable
  logic ext_en_q;
  logic tmr_en_q;
  logic ext_flag_q;
  logic tmr_flag_q;
  logic in_service_q;      // handler running
  logic sleeping_q;
  logic to_n_q;
  logic pd_n_q;
  logic take_q;
  logic [7:0] rd_q;
  logic [$clog2(SETUP_CYC_P+1)-1:0] hold_q; // cold setup counter
  logic [7:0] gpr_q [24];  // extra general bytes, kept over reset

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire adv_wr_w = wr_en_i & adv_mode_i;
  wire gpr_hit_w = adv_mode_i & (addr_i[4:3] == 2'b01) &
                   (addr_i[6:5] != 2'b00);
  wire wake_wr_w = adv_wr_w & (addr_i == ADR_WAKE);
  wire en_wr_w = adv_wr_w & (addr_i == ADR_IRQ_EN);
  wire pd_wr_w = adv_wr_w & (addr_i == ADR_IRQ_PD);
  wire tmr_wr_w = wr_en_i & (addr_i == ADR_TMR);

  ////////////////////////////////////////////////////////////////////////
  // reset sources and cold-reset hold
  wire cold_w = ~rst_b_i | f_q[7];
  wire wdt_to_w;
  wire warm_w = ~f_q[6] | wdt_to_w;
  wire sys_rst_w = cold_w | warm_w | (hold_q != '0);

  // cold events reload the hold; release lands on a clock edge
  always_ff @(posedge clk_i) begin
    if (cold_w) begin
      hold_q <= ($bits(hold_q))'(SETUP_CYC_P);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer, prescaler and watchdog datapath
  wire wdt_run_w = cfg_wdt_fuse_i & wake_q.soft_en;
  wire rc_tick_w = rise_w[5];
  wire wdt_clr_w = op_clrwdt_i | op_sleep_i;
  wire wdt_ovf_w = wdt_run_w & rc_tick_w & (wdt_q == 8'hff);
  // external edge by polarity, or every instruction cycle
  wire tsrc_w = sel_q.src_ext ?
                (sel_q.edge_fall ? fall_w[4] : rise_w[4]) : 1'b1;
  wire pre_in_w = sel_q.prescaler_assign ? wdt_ovf_w : tsrc_w;
  wire [7:0] mask_w = ps_mask(sel_q.ps, sel_q.prescaler_assign);
  wire pre_hit_w = pre_in_w & ((pre_q & mask_w) == mask_w);
  wire pre_clr_w = sel_q.prescaler_assign ? wdt_clr_w : tmr_wr_w;
  wire tmr_inc_w = sel_q.prescaler_assign ? tsrc_w : pre_hit_w;
  assign wdt_to_w = sel_q.prescaler_assign ? pre_hit_w : wdt_ovf_w;
  wire tmr_ovf_w = tmr_inc_w & ~tmr_wr_w & (tmr_q == 8'hff);

  // timer count keeps its value over warm reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tmr_q <= 8'h00;
    end else if (tmr_wr_w) begin
      tmr_q <= wr_data_i;
    end else if (tmr_inc_w) begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  // prescaler wraps on its own; the mask picks the tap
  always_ff @(posedge clk_i) begin
    if (sys_rst_w || pre_clr_w) begin
      pre_q <= 8'h00;
    end else if (pre_in_w) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // rc ticks arrive asleep or awake alike
  always_ff @(posedge clk_i) begin
    if (sys_rst_w || wdt_clr_w || !wdt_run_w) begin
      wdt_q <= 8'h00;
    end else if (rc_tick_w) begin
      wdt_q <= wdt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers and sleep
  wire ext_wake_w = wake_q.wake_en &
                    |(wake_q.pa_bits & fall_w[3:0]);
  wire ext_set_w = wake_q.irq_sel & wake_q.pa_bits[0] &
                   fall_w[0];

  // every reset clears wake control; select and direction go high
  always_ff @(posedge clk_i) begin
    if (sys_rst_w) begin
      wake_q <= WAKE_RST;
      sel_q <= SEL_RST;
      io_direction_q <= IO_DIRECTION_RST;
    end else begin
      if (wake_wr_w) begin
        wake_q <= {wr_data_i[7:5], 1'b0, wr_data_i[3:0]};
      end
      if (op_select_i) begin
        sel_q <= acc_i[5:0];
      end
      if (op_io_direction_i) begin
        io_direction_q <= acc_i;
      end
    end
  end

  // sleep ends only by external wake or by reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_w) begin
      sleeping_q <= 1'b0;
    end else if (ext_wake_w) begin
      sleeping_q <= 1'b0;
    end else if (op_sleep_i) begin
      sleeping_q <= 1'b1;
    end
  end

  // extra general bytes, no reset so contents survive warm reset
  always_ff @(posedge clk_i) begin
    if (wr_en_i && gpr_hit_w) begin
      gpr_q[gpr_idx(addr_i)] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt control
  wire req_w = (tmr_flag_q & tmr_en_q) | (ext_flag_q & ext_en_q);
  // asleep the request waits; the handler blocks nesting
  wire take_w = req_w & gie_q & ~in_service_q &
                ~sleeping_q & ~sys_rst_w;

  // enables; a take drops the global bit, return sets it
  always_ff @(posedge clk_i) begin
    if (sys_rst_w) begin
      {gie_q, ext_en_q, tmr_en_q} <= 3'b000;
    end else begin
      if (en_wr_w) begin
        gie_q <= wr_data_i[B_GIE];
        ext_en_q <= wr_data_i[B_EXT];
        tmr_en_q <= wr_data_i[B_TMR];
      end
      if (op_reti_i) begin
        gie_q <= 1'b1;
      end
      if (take_w) begin
        gie_q <= 1'b0;
      end
    end
  end

  // flags: writes can only clear, and a new event beats the clear;
  // reset discards anything raised before a non-external wake
  always_ff @(posedge clk_i) begin
    if (sys_rst_w) begin
      ext_flag_q <= 1'b0;
      tmr_flag_q <= 1'b0;
    end else begin
      ext_flag_q <= ext_set_w |
                    (ext_flag_q & ~(pd_wr_w & ~wr_data_i[B_EXT]));
      tmr_flag_q <= tmr_ovf_w |
                    (tmr_flag_q & ~(pd_wr_w & ~wr_data_i[B_TMR]));
    end
  end

  // handler tracking and the one-cycle take pulse
  always_ff @(posedge clk_i) begin
    if (sys_rst_w) begin
      in_service_q <= 1'b0;
      take_q <= 1'b0;
    end else begin
      take_q <= take_w;
      if (take_w) begin
        in_service_q <= 1'b1;
      end else if (op_reti_i) begin
        in_service_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timeout and powerdown flags, never written by software
  always_ff @(posedge clk_i) begin
    if (cold_w) begin
      {to_n_q, pd_n_q} <= 2'b11;
    end else if (wdt_to_w) begin
      {to_n_q, pd_n_q} <= {1'b0, ~sleeping_q};
    end else if (!f_q[6] && sleeping_q) begin
      {to_n_q, pd_n_q} <= 2'b10;
    end else if (op_clrwdt_i) begin
      {to_n_q, pd_n_q} <= 2'b11;
    end else if (op_sleep_i) begin
      {to_n_q, pd_n_q} <= 2'b10;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the strobe
  wire [7:0] rd_mux_w =
    gpr_hit_w ? gpr_q[gpr_idx(addr_i)] :
    (addr_i == ADR_TMR) ? tmr_q :
    (addr_i == ADR_STAT) ? {3'b000, to_n_q, pd_n_q, 3'b000} :
    (addr_i == ADR_PORTA) ? {4'h0, f_q[3:0]} :
    !adv_mode_i ? 8'h00 :
    (addr_i == ADR_WAKE) ? wake_q :
    (addr_i == ADR_IRQ_EN) ? {gie_q, 4'h0, ext_en_q, 1'b0, tmr_en_q} :
    (addr_i == ADR_IRQ_PD) ? {5'h00, ext_flag_q, 1'b0, tmr_flag_q} :
    8'h00;

  // capture read data
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_q <= 8'h00;
    end else if (rd_en_i) begin
      rd_q <= rd_mux_w;
    end
  end

  // outputs
  assign rd_data_o = rd_q;
  assign sys_rst_o = sys_rst_w;
  assign reset_vec_o = PC_RST;
  assign irq_take_o = take_q;
  assign irq_vec_o = IRQ_VEC;
  assign sleep_o = sleeping_q;
  assign io_direction_o = io_direction_q;
  assign timeout_flag_n_o = to_n_q;
  assign powerdown_flag_n_o = pd_n_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_WAKE_CLR: assert property ($past(sys_rst_w) |-> wake_q == WAKE_RST)
    else $error("wake control not cleared by reset");
  AST_WDT_GATE: assert property (!wdt_run_w |=> wdt_q == 8'h00)
    else $error("watchdog counts while disabled");
  AST_WAKE_UP: assert property (sleeping_q && ext_wake_w && !op_sleep_i
    |=> !sleeping_q) else $error("no wake on enabled edge");
  AST_EXT_SET: assert property (ext_set_w && !sys_rst_w |=> ext_flag_q)
    else $error("external edge did not set flag");
  AST_SLEEP_HOLD: assert property (sleeping_q |=> !irq_take_o)
    else $error("interrupt taken while asleep");
  AST_NO_NEST: assert property (take_q |-> !take_w ##1 !take_w)
    else $error("nested interrupt taken");
  AST_RETI: assert property (op_reti_i && !take_w && !sys_rst_w |=> gie_q)
    else $error("return did not set global enable");
  AST_W1_NOSET: assert property ($rose(tmr_flag_q) |-> $past(tmr_ovf_w))
    else $error("timer flag set without overflow");
  AST_TMR_INC: assert property (sel_q.prescaler_assign && !sel_q.src_ext &&
    !tmr_wr_w && !sys_rst_w |=> tmr_q == 8'($past(tmr_q) + 8'h01))
    else $error("timer missed an instruction cycle");
  AST_TO_CLR: assert property (wdt_to_w && !cold_w |=> !to_n_q)
    else $error("timeout flag not cleared");
  AST_HOLD: assert property (hold_q != '0 |-> sys_rst_o)
    else $error("reset released during setup time");

  COV_TAKE: cover property (take_w ##[1:50] op_reti_i);
  COV_WAKE: cover property (sleeping_q ##1 !sleeping_q);
  COV_WDT_TO: cover property (wdt_to_w);
endmodule // iwtc_ctrl

// file: test/iwtc_pins.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// far side: port a pins, reset pin, timer clock pin and rc oscillator
module iwtc_pins #(
  parameter int HOLD = 2,             // shortest level the device catches
  parameter realtime RC_HALF = 210.0  // half period of the rc clock, ns
) (
  // instruction clock
  input wire logic clk_i,
  // levels asked for by the bench
  input wire logic [3:0] pa_req_i,
  input wire logic rst_req_n_i,
  input wire logic tclk_req_i,
  input wire logic [3:0] lvd_req_i,
  // levels seen by the device
  output logic [3:0] pa_pin_o,
  output logic reset_pin_n_o,
  output logic tclk_pin_o,
  output logic wdt_rc_o,
  output logic [3:0] lvd_trip_o
);
  int held; // cycles since the last pin change
  // pins idle high, matching the device's synchroniser reset level,
  // so no false edge follows reset; supply good until asked otherwise
  initial begin
    pa_pin_o = 4'hf;
    reset_pin_n_o = 1'b1;
    tclk_pin_o = 1'b1;
    lvd_trip_o = 4'h0;
    held = 0;
  end
  // a new level goes out only after the old one stood long enough,
  // since a shorter pulse may slip past the sampling stages
  always @(negedge clk_i) begin
    held++;
    if (held >= HOLD) begin
      if ({pa_req_i, rst_req_n_i, tclk_req_i, lvd_req_i} !==
          {pa_pin_o, reset_pin_n_o, tclk_pin_o, lvd_trip_o}) begin
        lvd_trip_o = lvd_req_i;
        pa_pin_o = pa_req_i;
        reset_pin_n_o = rst_req_n_i;
        tclk_pin_o = tclk_req_i;
        held = 0;
      end
    end
  end
  // on-chip rc oscillator runs free, unrelated to the clock, also asleep
  initial begin
    wdt_rc_o = 1'b0;
    forever #(RC_HALF) wdt_rc_o = ~wdt_rc_o;
  end
endmodule // iwtc_pins

// file: test/irq_wake_timer_wdt_reset_ctrl_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module irq_wake_timer_wdt_reset_ctrl_bench;
  import iwtc_pkg::*;
  // stimulus, all changed at the falling edge
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic fuse = 1'b0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [6:0] addr_i = 7'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic [7:0] acc_i = 8'h00;
  logic [4:0] op = 5'h00; // select, io_direction, clrwdt, sleep, reti
  logic [3:0] pa_req = 4'hf;
  logic rst_req_n = 1'b1;
  logic tclk_req = 1'b1;
  logic [3:0] lvd_req = 4'h0;
  logic adv = 1'b1;
  // pins and device outputs
  logic [3:0] pa_pin, lvd;
  logic rpin_n, tclk, rc;
  logic [7:0] rd_data_o, io_direction_o;
  logic [10:0] reset_vec_o, irq_vec;
  logic sys_rst_o, irq_take_o, sleep_o, to_n, pd_n;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] q0, q1;
  int seen;
  localparam logic [6:0] ADRS [6] = '{7'h28, 7'h2f, 7'h48, 7'h4f,
                                     7'h68, 7'h6f};

  iwtc_ctrl #(.SETUP_CYC_P(8)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .adv_mode_i(adv), .cfg_wdt_fuse_i(fuse), .cfg_lvr_sel_i(2'b00),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
    .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .acc_i(acc_i),
    .op_select_i(op[0]), .op_io_direction_i(op[1]), .op_clrwdt_i(op[2]),
    .op_sleep_i(op[3]), .op_reti_i(op[4]), .pa_pin_i(pa_pin),
    .tclk_pin_i(tclk), .reset_pin_n_i(rpin_n), .wdt_rc_i(rc),
    .lvd_trip_i(lvd), .sys_rst_o(sys_rst_o), .reset_vec_o(reset_vec_o),
    .irq_take_o(irq_take_o), .irq_vec_o(irq_vec), .sleep_o(sleep_o),
    .io_direction_o(io_direction_o), .timeout_flag_n_o(to_n),
    .powerdown_flag_n_o(pd_n));
  iwtc_pins i_pins (.clk_i(clk_i), .pa_req_i(pa_req),
    .rst_req_n_i(rst_req_n), .tclk_req_i(tclk_req), .pa_pin_o(pa_pin),
    .reset_pin_n_o(rpin_n), .tclk_pin_o(tclk), .wdt_rc_o(rc),
    .lvd_trip_o(lvd), .lvd_req_i(lvd_req));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the watchdog runs take about 5700 cycles
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic stop_test;
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // an idle cycle follows every strobe, so that two calls in a row
  // never drop and raise the same strobe in one time step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    addr_i = a;
    wr_data_i = d;
    wr_en_i = 1'b1;
    cyc(1);
    wr_en_i = 1'b0;
    cyc(1);
  endtask
  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    addr_i = a;
    rd_en_i = 1'b1;
    cyc(1);
    rd_en_i = 1'b0;
    q = rd_data_o;
    cyc(1);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk(q & m, e);
  endtask
  task automatic ins(input int i, input logic [7:0] a);
    acc_i = a;
    op[i] = 1'b1;
    cyc(1);
    op = 5'h00;
    cyc(1);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    for (int n = 0; n < lim && sys_rst_o !== lvl; n++) cyc(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    cyc(6);
    chk(sys_rst_o, 1'b1);
    wait_rst(1'b0, 40);
    rdc(ADR_WAKE, 8'hff, 8'h00);
    rdc(ADR_IRQ_EN, 8'hff, 8'h00);
    rdc(ADR_IRQ_PD, 8'hff, 8'h00);
    chk({to_n, pd_n}, 2'b11);
    chk(io_direction_o, 8'hff);
    chk(reset_vec_o, 11'h7ff);
    chk(irq_vec, 11'h7fe);
    ins(1, 8'h3c);
    chk(io_direction_o, 8'h3c);
  endtask
  // extra bytes hold distinct data; a hole in the map reads zero
  task automatic t_map;
    foreach (ADRS[i]) wr(ADRS[i], 8'h5a ^ 8'(i));
    wr(ADR_WAKE, 8'h5f);
    wr(7'h23, 8'h55);
    foreach (ADRS[i]) rdc(ADRS[i], 8'hff, 8'h5a ^ 8'(i));
    rdc(ADR_WAKE, 8'hff, 8'h4f);
    rdc(7'h23, 8'hff, 8'h00);
    wr(ADR_WAKE, 8'h00);
    // outside advanced mode the wake control write is refused
    adv = 1'b0;
    wr(ADR_WAKE, 8'h40);
    adv = 1'b1;
    rdc(ADR_WAKE, 8'hff, 8'h00);
  endtask
  // the timer still idles on the external pin here, so no flag rises
  task automatic t_flags;
    wr(ADR_IRQ_PD, 8'hff);
    rdc(ADR_IRQ_PD, 8'hff, 8'h00);
  endtask
  task automatic t_timer;
    ins(0, 8'h08);
    rd(ADR_TMR, q0);
    cyc(3);
    rd(ADR_TMR, q1);
    chk(8'(q1 - q0), 8'd5);
    // prescaler on the timer at 1:4; a timer write clears it
    ins(2, 8'h00);
    ins(0, 8'h01);
    wr(ADR_TMR, 8'h00);
    cyc(9);
    rd(ADR_TMR, q0);
    chk(q0, 8'h02);
  endtask
  // three edges of the chosen kind, each level held four cycles
  task automatic t_tclk;
    for (int e = 0; e < 2; e++) begin
      ins(0, e ? 8'h38 : 8'h28);
      tclk_req = e[0];
      cyc(6);
      rd(ADR_TMR, q0);
      repeat (3) begin
        tclk_req = ~e[0];
        cyc(4);
        tclk_req = e[0];
        cyc(4);
      end
      cyc(6);
      rd(ADR_TMR, q1);
      chk(8'(q1 - q0), 8'd3);
    end
  endtask
  task automatic t_irq;
    ins(0, 8'h08);
    wr(ADR_TMR, 8'hf8);
    wr(ADR_IRQ_PD, 8'h00);
    wr(ADR_IRQ_EN, 8'h81);
    for (int n = 0; n < 20 && irq_take_o !== 1'b1; n++) cyc(1);
    chk(irq_take_o, 1'b1);
    cyc(1);
    chk(irq_take_o, 1'b0);
    rdc(ADR_IRQ_EN, 8'hff, 8'h01);
    rdc(ADR_IRQ_PD, 8'h01, 8'h01);
    wr(ADR_IRQ_EN, 8'h81);
    seen = 0;
    repeat (10) begin
      cyc(1);
      seen += int'(irq_take_o === 1'b1);
    end
    chk(seen, 0);
    wr(ADR_IRQ_PD, 8'h00);
    wr(ADR_IRQ_EN, 8'h00);
    ins(4, 8'h00);
    rdc(ADR_IRQ_EN, 8'hff, 8'h80);
  endtask
  // port a bit 0 raises the external flag only when selected
  task automatic t_ext;
    for (int s = 1; s >= 0; s--) begin
      wr(ADR_IRQ_PD, 8'h00);
      wr(ADR_WAKE, s ? 8'h21 : 8'h01);
      pa_req = 4'he;
      cyc(8);
      pa_req = 4'hf;
      cyc(6);
      rdc(ADR_IRQ_PD, 8'h04, s ? 8'h04 : 8'h00);
    end
  endtask
  task automatic t_sleep;
    wr(ADR_WAKE, 8'h42);
    ins(3, 8'h00);
    chk({sleep_o, pd_n}, 2'b10);
    pa_req = 4'hd;
    for (int n = 0; n < 12 && sleep_o !== 1'b0; n++) cyc(1);
    chk(sleep_o, 1'b0);
    pa_req = 4'hf;
    cyc(6);
  endtask
  // pin reset while awake leaves both status flags as they were
  task automatic t_pin;
    rst_req_n = 1'b0;
    wait_rst(1'b1, 10);
    chk(sys_rst_o, 1'b1);
    rst_req_n = 1'b1;
    wait_rst(1'b0, 20);
    chk({to_n, pd_n}, 2'b10);
    wr(ADR_STAT, 8'h18);
    rdc(ADR_STAT, 8'h18, 8'h10);
    rdc(ADR_WAKE, 8'hff, 8'h00);
  endtask
  // rate 1:1 means a time-out after 256 rc ticks, about 2700 cycles
  task automatic t_wdt;
    ins(2, 8'h00);
    ins(0, 8'h08);
    wr(ADR_WAKE, 8'h80);
    seen = 0;
    repeat (3000) begin
      cyc(1);
      seen += int'(sys_rst_o === 1'b1);
    end
    chk(seen, 0);
    fuse = 1'b1;
    wait_rst(1'b1, 3500);
    chk(sys_rst_o, 1'b1);
    wait_rst(1'b0, 20);
    chk({to_n, pd_n}, 2'b01);
    rdc(ADR_WAKE, 8'hff, 8'h00);
  endtask
  // a supply drop is a cold reset: full hold, both status flags set
  task automatic t_brown;
    lvd_req = 4'h1;
    wait_rst(1'b1, 10);
    chk(sys_rst_o, 1'b1);
    lvd_req = 4'h0;
    cyc(6);
    chk(sys_rst_o, 1'b1);
    wait_rst(1'b0, 30);
    chk({to_n, pd_n}, 2'b11);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(4);
    rst_b_i = 1'b1;
    t_reset();
    t_map();
    t_flags();
    t_timer();
    t_tclk();
    t_irq();
    t_ext();
    t_sleep();
    t_pin();
    t_wdt();
    t_brown();
    stop_test();
  end
endmodule // irq_wake_timer_wdt_reset_ctrl_bench
